// >>> include/gsp_pkg.sv
// constants shared by the serdes parallel-port logic
package gsp_pkg;
  localparam int          WORD_W       = 10;            // parallel word width
  localparam int          NIB_W        = 5;             // ddr half-word width
  localparam logic [9:0]  COMMA_POS    = 10'h17C;       // k28.5, bit 0 earliest
  localparam logic [9:0]  COMMA_NEG    = 10'h283;       // k28.5, other disparity
  localparam logic [3:0]  BIT_LAST     = 4'h9;          // last bit index of a word
  localparam logic [3:0]  HALF_FULL    = 4'h5;          // half period, full rate
  localparam logic [3:0]  HALF_SLOW    = 4'hA;          // half period, half rate
  localparam int          REF_MIN_MHZ  = 100;           // reference clock floor
  localparam int          REF_MAX_MHZ  = 185;           // reference clock ceiling
  // positions inside the synchroniser vector
  localparam int          SY_REF       = 0;
  localparam int          SY_TD        = 1;             // 10 bits from here
  localparam int          SY_RXP       = 11;
  localparam int          SY_RXN       = 12;
  localparam int          SY_WIDTH     = 13;
  localparam int          SY_LOOP      = 14;
  localparam int          SY_RATE      = 15;
  localparam int          SY_ALIGN     = 16;
  localparam int          SY_W         = 17;
endpackage

// >>> include/gsp_stream_if.sv
// valid/ready word stream between capture, buffer and serializer
`timescale 1ns/10ps
`default_nettype none
interface gsp_stream_if #(parameter int W = 10);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface
`default_nettype wire

// >>> logic/gsp_pair_buffer.sv
// two-entry buffer on the transmit word path
`timescale 1ns/10ps
`default_nettype none
module gsp_pair_buffer #(
  parameter int W = 10
) (
  input  wire logic sys_clk_in,
  input  wire logic srst_in,
  gsp_stream_if.sink   fill,
  gsp_stream_if.source drain
);
  logic [W-1:0] mem_reg [2];
  logic         wptr_reg;
  logic         rptr_reg;
  logic [1:0]   cnt_reg;
  logic         wptr_next;
  logic         rptr_next;
  logic [1:0]   cnt_next;
  logic         do_push;
  logic         do_pop;

  // honest flags: ready drops only when both slots hold words
  assign fill.ready  = (cnt_reg != 2'h2);
  assign drain.valid = (cnt_reg != 2'h0);
  assign drain.data  = mem_reg[rptr_reg];
  assign do_push     = fill.valid & fill.ready;
  assign do_pop      = drain.valid & drain.ready;

  // pointer and occupancy update
  always_comb begin
    wptr_next = wptr_reg ^ do_push;
    rptr_next = rptr_reg ^ do_pop;
    cnt_next  = cnt_reg + {1'b0, do_push} - {1'b0, do_pop};
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wptr_reg <= 1'b0;
      rptr_reg <= 1'b0;
      cnt_reg  <= 2'h0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg  <= cnt_next;
    end
  end

  // storage needs no reset, only valid slots are read
  always_ff @(posedge sys_clk_in) begin
    if (do_push) begin
      mem_reg[wptr_reg] <= fill.data;
    end
  end

  a_buf_no_over: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    cnt_reg == 2'h2 |-> !fill.ready)
    else $error("buffer accepts a word while full");
endmodule
`default_nettype wire

// >>> logic/gsp_serdes_port.sv
// parallel side of the serdes: capture, serialize, deserialize, align
`timescale 1ns/10ps
`default_nettype none
// Function
// - loopback floats serial transmit, else drive it
// - ten-bit mode captures word on reference rise
// - ddr captures both edges, rise holds upper
// - ten-bit word serialized bit zero first
// - ddr uses five lines, bit zero first
// - ten-bit receive word, bit zero earliest
// - ddr drives five receive lines, upper low
// - half rate: word valid on both rising edges
// - realignment shifts recovered clock phase
// - realignment stretches pulse, never shortens it
// - half rate: clocks latch alternating words
// - normal rate: primary only, word rate
// - ddr: primary only, nibbles on both edges
// - both selects low gives half-rate clock pair
// - loopback feeds own transmit stream to receiver
// - alignment enable searches comma, else unframed
module gsp_serdes_port (
  input  wire logic       sys_clk_in,
  input  wire logic       srst_in,
  input  wire logic       reference_clock_in,
  input  wire logic [9:0] parallel_tx_word_in,
  input  wire logic       serial_rx_pos_in,
  input  wire logic       serial_rx_neg_in,
  input  wire logic       interface_width_select_in,
  input  wire logic       loopback_enable_in,
  input  wire logic       recovered_clock_rate_select_in,
  input  wire logic       comma_align_enable_in,
  output logic            serial_tx_pos_out,
  output logic            serial_tx_neg_out,
  output logic            serial_tx_oe_out,
  output logic [9:0]      parallel_rx_word_out,
  output logic            recovered_clock_primary_out,
  output logic            recovered_clock_secondary_out,
  output logic            comma_detect_out,
  output logic            tx_overflow_out
);
  logic [gsp_pkg::SY_W-1:0] s1_reg;
  logic [gsp_pkg::SY_W-1:0] s2_reg;
  logic                     ref_d_reg;
  logic       ref_rise;
  logic       ref_fall;
  logic       ddr;
  logic       half_rate;
  logic       loop;
  logic [9:0] td;
  logic [9:0] cap_reg;
  logic [9:0] cap_next;
  logic       push_reg;
  logic       push_next;
  logic [9:0] sh_reg;
  logic [9:0] sh_next;
  logic [3:0] bcnt_reg;
  logic [3:0] bcnt_next;
  logic       txbit_reg;
  logic       txbit_next;
  logic       rxbit;
  logic [9:0] rsh_reg;
  logic [9:0] rsh_next;
  logic [3:0] rcnt_reg;
  logic [3:0] rcnt_next;
  logic [9:0] word_reg;
  logic [9:0] word_next;
  logic       hit;
  logic       realign_reg;
  logic       realign_next;
  logic [3:0] hcnt_reg;
  logic [3:0] hcnt_next;
  logic [3:0] half_len;
  logic       prim_reg;
  logic       prim_next;
  logic       sec_reg;
  logic       sec_next;
  logic       toggle;
  logic [9:0] rword_reg;
  logic [9:0] rword_next;

  gsp_stream_if #(.W(gsp_pkg::WORD_W)) cap_if ();
  gsp_stream_if #(.W(gsp_pkg::WORD_W)) ser_if ();

  // every pin but clock and reset passes two flops; the reference clock is only sampled
  always_ff @(posedge sys_clk_in) begin
    s1_reg    <= {comma_align_enable_in, recovered_clock_rate_select_in,
                  loopback_enable_in, interface_width_select_in,
                  serial_rx_neg_in, serial_rx_pos_in, parallel_tx_word_in,
                  reference_clock_in};
    s2_reg    <= s1_reg;
    ref_d_reg <= s2_reg[gsp_pkg::SY_REF];
  end

  // decoded modes and reference edges
  assign ref_rise  = s2_reg[gsp_pkg::SY_REF] & ~ref_d_reg;
  assign ref_fall  = ~s2_reg[gsp_pkg::SY_REF] & ref_d_reg;
  assign ddr       = s2_reg[gsp_pkg::SY_WIDTH];
  assign half_rate = ~ddr & ~s2_reg[gsp_pkg::SY_RATE];
  assign loop      = s2_reg[gsp_pkg::SY_LOOP];
  assign td        = s2_reg[gsp_pkg::SY_TD +: gsp_pkg::WORD_W];

  // transmit capture; ddr word opens with the upper half on the rise
  always_comb begin
    cap_next  = cap_reg;
    push_next = 1'b0;
    if (!ddr && ref_rise) begin
      cap_next  = td;
      push_next = 1'b1;
    end else if (ddr && ref_rise) begin
      cap_next[9:5] = td[4:0];
    end else if (ddr && ref_fall) begin
      cap_next[4:0] = td[4:0];
      push_next     = 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cap_reg  <= 10'h000;
      push_reg <= 1'b0;
    end else begin
      cap_reg  <= cap_next;
      push_reg <= push_next;
    end
  end

  assign cap_if.valid    = push_reg;
  assign cap_if.data     = cap_reg;
  // a word arriving on a full buffer is flagged, never silently merged
  assign tx_overflow_out = push_reg & ~cap_if.ready;

  gsp_pair_buffer #(.W(gsp_pkg::WORD_W)) u_buf (
    .sys_clk_in (sys_clk_in),
    .srst_in    (srst_in),
    .fill       (cap_if),
    .drain      (ser_if)
  );

  // serializer pulls the next word only once the last bit is out
  assign ser_if.ready = (bcnt_reg == 4'h0);
  always_comb begin
    sh_next    = sh_reg >> 1;
    bcnt_next  = bcnt_reg - 4'h1;
    txbit_next = sh_reg[0];
    if (bcnt_reg == 4'h0) begin
      bcnt_next  = 4'h0;
      txbit_next = 1'b0;                                     // idle line
      sh_next    = sh_reg;
      if (ser_if.valid) begin
        txbit_next = ser_if.data[0];
        sh_next    = ser_if.data >> 1;
        bcnt_next  = gsp_pkg::BIT_LAST;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      sh_reg    <= 10'h000;
      bcnt_reg  <= 4'h0;
      txbit_reg <= 1'b0;
    end else begin
      sh_reg    <= sh_next;
      bcnt_reg  <= bcnt_next;
      txbit_reg <= txbit_next;
    end
  end

  // differential pair floats while looped back
  assign serial_tx_pos_out = txbit_reg;
  assign serial_tx_neg_out = ~txbit_reg;
  assign serial_tx_oe_out  = ~loop;

  // receive path: own stream in loopback, else the line
  assign rxbit = loop ? txbit_reg :
                 (s2_reg[gsp_pkg::SY_RXP] & ~s2_reg[gsp_pkg::SY_RXN]);

  // deserializer shifts in at the top so bit 0 ends up earliest
  always_comb begin
    rsh_next     = {rxbit, rsh_reg[9:1]};
    hit          = s2_reg[gsp_pkg::SY_ALIGN] &&
                   (rsh_next == gsp_pkg::COMMA_POS || rsh_next == gsp_pkg::COMMA_NEG);
    realign_next = hit && (rcnt_reg != gsp_pkg::BIT_LAST);
    word_next    = word_reg;
    rcnt_next    = rcnt_reg + 4'h1;
    if (hit || rcnt_reg == gsp_pkg::BIT_LAST) begin
      word_next = rsh_next;
      rcnt_next = 4'h0;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      rsh_reg          <= 10'h000;
      rcnt_reg         <= 4'h0;
      word_reg         <= 10'h000;
      realign_reg      <= 1'b0;
      comma_detect_out <= 1'b0;
    end else begin
      rsh_reg          <= rsh_next;
      rcnt_reg         <= rcnt_next;
      word_reg         <= word_next;
      realign_reg      <= realign_next;
      comma_detect_out <= hit;
    end
  end

  // recovered clocks; realign restarts the half count with the level held,
  // so the running pulse only grows and the phase follows the new boundary
  assign half_len = half_rate ? gsp_pkg::HALF_SLOW : gsp_pkg::HALF_FULL;
  assign toggle   = !realign_reg && (hcnt_reg >= half_len - 4'h1);
  always_comb begin
    hcnt_next  = hcnt_reg + 4'h1;
    prim_next  = prim_reg;
    rword_next = rword_reg;
    if (realign_reg) begin
      hcnt_next = 4'h0;
      // a held low level has latched nothing yet, so the freshly aligned word
      // may change now and still stand at the next rise; otherwise the next fall latches it
      if (!half_rate && !ddr && !prim_reg) begin
        rword_next = word_reg;
      end
    end else if (toggle) begin
      hcnt_next = 4'h0;
      prim_next = ~prim_reg;
      if (half_rate) begin
        rword_next = word_reg;
      end else if (ddr) begin
        // lower nibble after the fall, upper after the rise
        rword_next = prim_reg ? {5'h00, word_reg[4:0]} :
                                {5'h00, word_reg[9:5]};
      end else if (prim_reg) begin
        rword_next = word_reg;
      end
    end
    sec_next = half_rate ? ~prim_next : 1'b0;
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      hcnt_reg  <= 4'h0;
      prim_reg  <= 1'b0;
      sec_reg   <= 1'b0;
      rword_reg <= 10'h000;
    end else begin
      hcnt_reg  <= hcnt_next;
      prim_reg  <= prim_next;
      sec_reg   <= sec_next;
      rword_reg <= rword_next;
    end
  end

  assign parallel_rx_word_out          = rword_reg;
  assign recovered_clock_primary_out   = prim_reg;
  assign recovered_clock_secondary_out = sec_reg;

  a_tx_float_loop: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    serial_tx_oe_out != loop) else $error("tx enable wrong for loopback");
  a_tbi_rise_cap: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (ref_rise && !ddr) |=> cap_reg == $past(td) && push_reg)
    else $error("ten-bit word not captured on rise");
  a_ddr_upper_cap: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (ref_rise && ddr) |=> cap_reg[9:5] == $past(td[4:0]) && !push_reg)
    else $error("ddr rise nibble not in upper half");
  a_ser_bit_zero: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (ser_if.valid && ser_if.ready) |=> txbit_reg == $past(ser_if.data[0])
      ##1 txbit_reg == $past(ser_if.data[1], 2))
    else $error("serial order not bit zero first");
  a_ddr_upper_low: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (toggle && ddr) |=> rword_reg[9:5] == 5'h00)
    else $error("ddr upper receive lines not low");
  a_stretch_level: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    realign_reg |=> prim_reg == $past(prim_reg) && hcnt_reg == 4'h0)
    else $error("realign shortened the clock pulse");
  // both clocks leave reset low, so the first cycle after release is exempt
  a_half_opposite: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    (half_rate && $past(half_rate) && !$past(srst_in)) |-> sec_reg == ~prim_reg)
    else $error("half-rate clocks not opposite");
  a_full_sec_low: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !half_rate |=> !sec_reg) else $error("secondary clock runs off half rate");
  a_loop_route: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    loop |-> rxbit == txbit_reg) else $error("loopback not routed");
  a_align_off: assert property (@(posedge sys_clk_in) disable iff (srst_in)
    !s2_reg[gsp_pkg::SY_ALIGN] |=> !realign_reg) else $error("realign while disabled");
endmodule
`default_nettype wire

// >>> verification/gsp_proto_model.sv
// protocol-side model: reference clock and transmit word pins
`timescale 1ns/10ps
`default_nettype none
module gsp_proto_model (
  input  wire logic       ddr_in,
  input  wire logic [9:0] word_in,
  output logic            ref_clk_out,
  output logic [9:0]      tx_word_out
);
  // free-running reference at the bench link rate, never stopped
  initial begin
    ref_clk_out = 1'b0;
    forever #62.5 ref_clk_out = ~ref_clk_out;
  end
  // data moves mid-phase so it is settled around both edges
  initial begin
    tx_word_out = 10'h000;
    forever begin
      @(ref_clk_out);
      #31;
      if (!ddr_in) begin
        tx_word_out = word_in;
      end else begin
        // idle upper lines keep changing, so the device must ignore them
        tx_word_out[9:5] = ~tx_word_out[9:5];
        tx_word_out[4:0] = ref_clk_out ? word_in[4:0] : word_in[9:5];
      end
    end
  end
endmodule
`default_nettype wire

// >>> verification/gsp_serdes_port_test.sv
// self-checking bench for the serdes parallel port
`timescale 1ns/10ps
`default_nettype none
module gsp_serdes_port_test;
  logic       sys_clk_in;
  logic       srst_in;
  logic       ref_clk;
  logic       rx_pos;
  logic       width_sel;
  logic       loop_en;
  logic       rate_sel;
  logic       align_en;
  logic [9:0] send_word;
  logic [9:0] tx_word;
  logic [9:0] rx_word;
  logic [9:0] w;
  logic       pos;
  logic       neg;
  logic       oe;
  logic       recovered_clock_primary;
  logic       recovered_clock_secondary;
  logic       comma;
  logic       ovf;
  logic       lvl;
  int         failures;
  int         n_checks;
  int         cycles;
  int         n;
  int         n_ovf;
  int         n_inv;

  gsp_proto_model partner_u (
    .ddr_in      (width_sel),
    .word_in     (send_word),
    .ref_clk_out (ref_clk),
    .tx_word_out (tx_word)
  );

  gsp_serdes_port dut_u (
    .sys_clk_in                     (sys_clk_in),
    .srst_in                        (srst_in),
    .reference_clock_in             (ref_clk),
    .parallel_tx_word_in            (tx_word),
    .serial_rx_pos_in               (rx_pos),
    .serial_rx_neg_in               (~rx_pos),
    .interface_width_select_in      (width_sel),
    .loopback_enable_in             (loop_en),
    .recovered_clock_rate_select_in (rate_sel),
    .comma_align_enable_in          (align_en),
    .serial_tx_pos_out              (pos),
    .serial_tx_neg_out              (neg),
    .serial_tx_oe_out               (oe),
    .parallel_rx_word_out           (rx_word),
    .recovered_clock_primary_out    (recovered_clock_primary),
    .recovered_clock_secondary_out  (recovered_clock_secondary),
    .comma_detect_out               (comma),
    .tx_overflow_out                (ovf)
  );

  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end

  // external line toggles every bit so a stale level never looks valid
  initial begin
    rx_pos = 1'b0;
    forever @(negedge sys_clk_in) rx_pos <= ~rx_pos;
  end

  // watches needing no stimulus: overflow never pulses, neg mirrors pos
  initial begin
    n_ovf = 0;
    n_inv = 0;
    forever begin
      @(negedge sys_clk_in);
      if (!srst_in && ovf !== 1'b0) n_ovf++;
      if (!srst_in && neg !== ~pos) n_inv++;
    end
  end

  // hang guard, well above the several hundred cycles the tests need
  initial begin
    cycles = 0;
    forever begin
      @(posedge sys_clk_in);
      cycles++;
      if (cycles == 8000) begin
        failures++;
        stop_test();
      end
    end
  end

  task automatic chk(input logic [9:0] got, input logic [9:0] exp);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // frame start: four idle zeros then a one (test words have bit 0 set)
  task automatic collect(output logic [9:0] wd);
    int z;
    int k;
    z = 0;
    wd = 10'h000;
    for (k = 0; k < 400 && !(z >= 4 && pos === 1'b1); k++) begin
      z = (pos === 1'b0) ? z + 1 : 0;
      @(negedge sys_clk_in);
    end
    for (int i = 0; i < 10; i++) begin
      wd[i] = pos;
      @(negedge sys_clk_in);
    end
  endtask

  // primary clock period in system cycles, rise to rise
  task automatic period(output int p);
    p = 0;
    while (recovered_clock_primary !== 1'b0 && p < 100) begin @(negedge sys_clk_in); p++; end
    while (recovered_clock_primary !== 1'b1 && p < 100) begin @(negedge sys_clk_in); p++; end
    p = 0;
    while (recovered_clock_primary === 1'b1 && p < 100) begin @(negedge sys_clk_in); p++; end
    while (recovered_clock_primary === 1'b0 && p < 100) begin @(negedge sys_clk_in); p++; end
  endtask

  task automatic stop_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  initial begin
    failures = 0;
    n_checks = 0;
    srst_in = 1'b1;
    width_sel = 1'b0;
    loop_en = 1'b0;
    rate_sel = 1'b1;
    align_en = 1'b0;
    send_word = 10'h2A5;
    repeat (12) @(negedge sys_clk_in);
    srst_in = 1'b0;
    repeat (80) @(negedge sys_clk_in);
    chk({9'h000, oe}, 10'h001);
    collect(w);
    chk(w, 10'h2A5);
    // clock shapes are measured with alignment off so no stretch intrudes
    period(n);
    chk(n[9:0], 10'h00A);
    chk({9'h000, recovered_clock_secondary}, 10'h000);
    rate_sel = 1'b0;
    repeat (40) @(negedge sys_clk_in);
    period(n);
    chk(n[9:0], 10'h014);
    chk({9'h000, recovered_clock_secondary}, {9'h000, ~recovered_clock_primary});
    width_sel = 1'b1;
    send_word = 10'h1B3;
    repeat (100) @(negedge sys_clk_in);
    collect(w);
    chk(w, 10'h1B3);
    period(n);
    chk(n[9:0], 10'h00A);
    chk({9'h000, recovered_clock_secondary}, 10'h000);
    chk({5'h00, rx_word[9:5]}, 10'h000);
    width_sel = 1'b0;
    rate_sel = 1'b1;
    loop_en = 1'b1;
    send_word = gsp_pkg::COMMA_POS;
    repeat (40) @(negedge sys_clk_in);
    chk({9'h000, oe}, 10'h000);
    n = 0;
    repeat (200) begin
      @(negedge sys_clk_in);
      if (comma === 1'b1) n++;
    end
    chk(n[9:0], 10'h000);
    align_en = 1'b1;
    n = 0;
    while (comma !== 1'b1 && n < 300) begin @(negedge sys_clk_in); n++; end
    // the first hit may land on a boundary already in step; the next one realigns
    @(negedge sys_clk_in);
    while (comma !== 1'b1 && n < 300) begin @(negedge sys_clk_in); n++; end
    chk({9'h000, comma}, 10'h001);
    lvl = recovered_clock_primary;
    repeat (3) @(negedge sys_clk_in);
    chk({9'h000, recovered_clock_primary}, {9'h000, lvl});
    // comma word stands from the held low level or from the first fall after it
    repeat (5) @(negedge sys_clk_in);
    chk(rx_word, gsp_pkg::COMMA_POS);
    chk(n_ovf[9:0], 10'h000);
    chk(n_inv[9:0], 10'h000);
    stop_test();
  end
endmodule
`default_nettype wire
